// >>> core/sas_sequencer.sv
`include "sas_regs.svh"
module sas_sequencer #(
  parameter int PRESENT_INPUTS = 13
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata,
  input  wire logic        extTrigger,
  input  wire logic        timerTrigger,
  input  wire logic [12:0] otherModulePortConfig,
  input  wire logic        sarBitDone,
  output logic             sampleConnect,
  output logic             sarConvert,
  output logic [4:0]       chan0PosSelect,
  output logic             chan0NegSelect,
  output logic             chan123PosSelect,
  output logic [1:0]       chan123NegSelect,
  output logic [1:0]       activeChannels,
  output logic             selectNegReference,
  output logic [12:0]      pinDigitalMode,
  output logic [12:0]      muxToGround,
  output logic             bufferHalf,
  output logic [3:0]       resultSlot,
  output logic             irq
);
  localparam logic [15:0] RSV = `SAS_RESET_VAL;

  logic [15:0] ctl1_q, ctl2_q, ctl3_q, chs123_q, chs0_q, scan_q, port_analog_config_bits_q;
  logic [1:0]  irqSt_q, irqMsk_q;
  logic [15:0] regRdata_q;
  sas_pkg::sas_state_e state_q;
  logic        sampleBit_q;
  logic        done_q;
  logic [7:0]  tadDiv_q;
  logic        tadTick;
  logic [4:0]  sampleCnt_q;
  logic [4:0]  convCnt_q;
  logic [3:0]  seqCnt_q;
  logic        bufHalf_q;
  logic        altB_q;
  logic [3:0]  scanIdx_q;
  logic [3:0]  slot_q;

  logic        twelveBit, autoSampleStart, scanEnable, splitBufferFill, altInputSelect;
  logic [2:0]  trigSel;
  logic [1:0]  chanCount;
  logic [3:0]  intRate;
  logic [4:0]  autoSampleTime;
  logic [7:0]  convClockDivider;
  logic        startConv, convEnd, wrCtl1, wrSt, swSampleSet, swSampleClr, swDoneClr;
  logic [4:0]  convLen;
  logic [3:0]  nextScan;
  logic        nextScanFound;

  assign twelveBit        = ctl1_q[10];
  assign trigSel          = ctl1_q[7:5];
  assign autoSampleStart  = ctl1_q[2];
  assign scanEnable       = ctl2_q[10];
  assign chanCount        = twelveBit ? 2'b00 : ctl2_q[9:8];
  assign intRate          = ctl2_q[5:2];
  assign splitBufferFill  = ctl2_q[1];
  assign altInputSelect   = ctl2_q[0];
  assign autoSampleTime   = ctl3_q[12:8];
  assign convClockDivider = ctl3_q[7:0];
  assign convLen          = twelveBit ? `SAS_CONV_TAD_12 : `SAS_CONV_TAD_10;

  assign wrCtl1      = regWr && regAddr == `SAS_OFS_CTL1;
  assign wrSt        = regWr && regAddr == `SAS_OFS_IRQST;
  assign swSampleSet = wrCtl1 && regWdata[1] && !sampleBit_q;
  assign swSampleClr = wrCtl1 && !regWdata[1] && sampleBit_q;
  assign swDoneClr   = wrCtl1 && !regWdata[0];

  // Converter clock period: system clock times divider plus one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tadDiv_q <= 8'h00;
    end else if (startConv || (state_q != sas_pkg::SAS_CONVERT && state_q != sas_pkg::SAS_SAMPLE)) begin
      // Restart at the end of sampling so the first conversion period is a whole one
      tadDiv_q <= 8'h00;
    end else if (tadDiv_q >= convClockDivider) begin
      tadDiv_q <= 8'h00;
    end else begin
      tadDiv_q <= tadDiv_q + 8'h01;
    end
  end
  assign tadTick = tadDiv_q >= convClockDivider;

  // Conversion start: trigger source ends sampling
  always_comb begin
    startConv = 1'b0;
    if (state_q == sas_pkg::SAS_SAMPLE) begin
      case (trigSel)
        `SAS_TRIG_MANUAL: startConv = swSampleClr;
        `SAS_TRIG_EXT:    startConv = extTrigger;
        `SAS_TRIG_TIMER:  startConv = timerTrigger;
        `SAS_TRIG_AUTO:   startConv = tadTick && {1'b0, sampleCnt_q} + 6'h01 >= {1'b0, autoSampleTime};
        default:          startConv = 1'b0;
      endcase
    end
  end
  assign convEnd = state_q == sas_pkg::SAS_CONVERT && tadTick && convCnt_q == convLen - 5'h01;

  // Sample, hold, convert sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= sas_pkg::SAS_IDLE;
      sampleBit_q <= 1'b0;
      sampleCnt_q <= 5'h00;
      convCnt_q   <= 5'h00;
    end else begin
      case (state_q)
        sas_pkg::SAS_IDLE: begin
          if (swSampleSet || autoSampleStart) begin
            state_q     <= sas_pkg::SAS_SAMPLE;
            sampleBit_q <= 1'b1;
            sampleCnt_q <= 5'h00;
          end
        end
        sas_pkg::SAS_SAMPLE: begin
          if (startConv) begin
            state_q     <= sas_pkg::SAS_CONVERT;
            sampleBit_q <= 1'b0;
            convCnt_q   <= 5'h00;
          end else if (tadTick && sampleCnt_q != 5'h1f) begin
            sampleCnt_q <= sampleCnt_q + 5'h01;
          end
        end
        sas_pkg::SAS_CONVERT: begin
          if (convEnd) begin
            if (autoSampleStart) begin
              state_q     <= sas_pkg::SAS_SAMPLE;
              sampleBit_q <= 1'b1;
              sampleCnt_q <= 5'h00;
            end else begin
              state_q <= sas_pkg::SAS_IDLE;
            end
          end else if (tadTick) begin
            convCnt_q <= convCnt_q + 5'h01;
          end
        end
        default: state_q <= sas_pkg::SAS_IDLE;
      endcase
    end
  end

  // Done flag: completion wins over a software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (convEnd) begin
      done_q <= 1'b1;
    end else if (startConv || swDoneClr) begin
      done_q <= 1'b0;
    end
  end

  // Sequence counting, buffer half and input alternation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqCnt_q  <= 4'h0;
      bufHalf_q <= 1'b0;
      altB_q    <= 1'b0;
      slot_q    <= 4'h0;
    end else if (convEnd) begin
      altB_q <= altInputSelect ? !altB_q : 1'b0;
      if (seqCnt_q >= intRate) begin
        seqCnt_q  <= 4'h0;
        bufHalf_q <= splitBufferFill ? !bufHalf_q : 1'b0;
        slot_q    <= 4'h0;
      end else begin
        seqCnt_q <= seqCnt_q + 4'h1;
        slot_q   <= slot_q + 4'h1;
      end
    end
  end

  // Next selected scan input above the current one, wrapping
  always_comb begin
    nextScan      = 4'h0;
    nextScanFound = 1'b0;
    for (int i = `SAS_NUM_INPUTS - 1; i >= 0; i--) begin
      if (scan_q[i] && 4'(i) > scanIdx_q) begin
        nextScan      = 4'(i);
        nextScanFound = 1'b1;
      end
    end
    if (!nextScanFound) begin
      for (int i = `SAS_NUM_INPUTS - 1; i >= 0; i--) begin
        if (scan_q[i]) begin
          nextScan = 4'(i);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanIdx_q <= 4'hf;
    end else if (!scanEnable) begin
      scanIdx_q <= 4'hf;
    end else if (convEnd || (state_q == sas_pkg::SAS_IDLE && scanIdx_q == 4'hf)) begin
      scanIdx_q <= nextScan;
    end
  end

  // Register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q   <= RSV;
      ctl2_q   <= RSV;
      ctl3_q   <= RSV;
      chs123_q <= RSV;
      chs0_q   <= RSV;
      scan_q   <= RSV;
      port_analog_config_bits_q   <= RSV;
      irqMsk_q <= 2'b00;
    end else if (regWr) begin
      case (regAddr)
        `SAS_OFS_CTL1:   ctl1_q   <= regWdata & 16'h87ec;
        `SAS_OFS_CTL2:   ctl2_q   <= regWdata & 16'he73f;
        `SAS_OFS_CTL3:   ctl3_q   <= regWdata & 16'h9fff;
        `SAS_OFS_CHS123: chs123_q <= regWdata & 16'h0707;
        `SAS_OFS_CHS0:   chs0_q   <= regWdata & 16'h9f9f;
        `SAS_OFS_SCAN:   scan_q   <= regWdata & 16'h1fff;
        `SAS_OFS_PORT_ANALOG_CONFIG_BITS:   port_analog_config_bits_q   <= regWdata & 16'h1fff;
        `SAS_OFS_IRQMSK: irqMsk_q <= regWdata[1:0];
        default:         ;
      endcase
    end
  end

  // Status bit 0 sequence-rate event, bit 1 conversion done; set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSt_q <= 2'b00;
    end else begin
      irqSt_q[0] <= (convEnd && seqCnt_q >= intRate) || (irqSt_q[0] && !(wrSt && regWdata[0]));
      irqSt_q[1] <= convEnd || (irqSt_q[1] && !(wrSt && regWdata[1]));
    end
  end
  assign irq = |(irqSt_q & irqMsk_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_q <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `SAS_OFS_CTL1:   regRdata_q <= {ctl1_q[15:2], sampleBit_q, done_q};
        `SAS_OFS_CTL2:   regRdata_q <= {ctl2_q[15:10], chanCount, bufHalf_q, 1'b0, ctl2_q[5:0]};
        `SAS_OFS_CTL3:   regRdata_q <= ctl3_q;
        `SAS_OFS_CHS123: regRdata_q <= twelveBit ? 16'h0000 : chs123_q;
        `SAS_OFS_CHS0:   regRdata_q <= chs0_q;
        `SAS_OFS_SCAN:   regRdata_q <= scan_q;
        `SAS_OFS_PORT_ANALOG_CONFIG_BITS:   regRdata_q <= port_analog_config_bits_q;
        `SAS_OFS_IRQST:  regRdata_q <= {14'h0000, irqSt_q};
        `SAS_OFS_IRQMSK: regRdata_q <= {14'h0000, irqMsk_q};
        default:         regRdata_q <= 16'h0000;
      endcase
    end else begin
      regRdata_q <= 16'h0000;
    end
  end
  assign regRdata = regRdata_q;

  // Pin configuration per input; absent inputs stay analog and inert
  for (genvar g = 0; g < `SAS_NUM_INPUTS; g++) begin : g_pin
    logic digital;
    assign digital = g < PRESENT_INPUTS && (port_analog_config_bits_q[g] || otherModulePortConfig[g]);
    assign pinDigitalMode[g] = digital;
    assign muxToGround[g]    = digital;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan0PosSelect     <= 5'h00;
      chan0NegSelect     <= 1'b0;
      chan123PosSelect   <= 1'b0;
      chan123NegSelect   <= 2'b00;
      selectNegReference <= 1'b0;
    end else begin
      if (scanEnable && scanIdx_q != 4'hf) begin
        chan0PosSelect     <= {1'b0, scanIdx_q};
        selectNegReference <= {1'b0, scanIdx_q} >= 5'(PRESENT_INPUTS);
      end else begin
        chan0PosSelect     <= altB_q ? chs0_q[12:8] : chs0_q[4:0];
        selectNegReference <= 1'b0;
      end
      chan0NegSelect   <= altB_q ? chs0_q[15] : chs0_q[7];
      chan123PosSelect <= altB_q ? chs123_q[8] : chs123_q[0];
      chan123NegSelect <= altB_q ? chs123_q[10:9] : chs123_q[2:1];
    end
  end

  assign sampleConnect  = state_q == sas_pkg::SAS_SAMPLE;
  assign sarConvert     = state_q == sas_pkg::SAS_CONVERT;
  assign activeChannels = chanCount;
  assign bufferHalf     = bufHalf_q;
  assign resultSlot     = slot_q;
  logic unusedBit;
  assign unusedBit = sarBitDone;
endmodule : sas_sequencer

// >>> core/sas_regs.svh
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH
`define SAS_OFS_CTL1   4'h0
`define SAS_OFS_CTL2   4'h1
`define SAS_OFS_CTL3   4'h2
`define SAS_OFS_CHS123 4'h3
`define SAS_OFS_CHS0   4'h4
`define SAS_OFS_SCAN   4'h5
`define SAS_OFS_PORT_ANALOG_CONFIG_BITS   4'h6
`define SAS_OFS_IRQST  4'h7
`define SAS_OFS_IRQMSK 4'h8
`define SAS_TRIG_MANUAL 3'h0
`define SAS_TRIG_EXT    3'h1
`define SAS_TRIG_TIMER  3'h2
`define SAS_TRIG_AUTO   3'h7
`define SAS_CONV_TAD_10 5'h0c
`define SAS_CONV_TAD_12 5'h0e
`define SAS_NUM_INPUTS  13
`define SAS_RESET_VAL   16'h0000
`endif

// >>> core/sas_pkg.sv
package sas_pkg;
  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_CONVERT} sas_state_e;
endpackage : sas_pkg

// >>> test/sas_sequencer_sva.sv
`include "sas_regs.svh"
module sas_sequencer_sva #(
  parameter int PRESENT_INPUTS = 13
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire logic [12:0] otherModulePortConfig,
  input wire logic        sampleConnect,
  input wire logic        sarConvert,
  input wire logic [12:0] pinDigitalMode,
  input wire logic [12:0] muxToGround,
  input wire logic        irq
);
  logic [12:0] scanQ, pcfgQ, presMask;
  logic [2:0]  trigQ;
  logic [1:0]  maskQ;
  logic [7:0]  convCntQ;
  assign presMask = 13'h1fff >> (13 - PRESENT_INPUTS);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanQ <= '0;
      pcfgQ <= '0;
      trigQ <= '0;
      maskQ <= '0;
    end else if (regWr) begin
      if (regAddr == `SAS_OFS_SCAN) scanQ <= regWdata[12:0];
      if (regAddr == `SAS_OFS_PORT_ANALOG_CONFIG_BITS) pcfgQ <= regWdata[12:0];
      if (regAddr == `SAS_OFS_CTL1) trigQ <= regWdata[7:5];
      if (regAddr == `SAS_OFS_IRQMSK) maskQ <= regWdata[1:0];
    end
  end
  // Counts cycles spent converting so the length can be judged at the fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) convCntQ <= '0;
    else convCntQ <= sarConvert ? convCntQ + 8'h01 : 8'h00;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_excl; !(sampleConnect && sarConvert); endproperty
  property p_after; $rose(sarConvert) |-> $past(sampleConnect); endproperty
  property p_len; $fell(sarConvert) |-> convCntQ >= 8'd12; endproperty
  property p_start;
    !sampleConnect && !sarConvert && regWr && regAddr == `SAS_OFS_CTL1 && regWdata[1] |=> sampleConnect;
  endproperty
  property p_end;
    trigQ == 3'h0 && sampleConnect && regWr && regAddr == `SAS_OFS_CTL1 && regWdata[7:5] == 3'h0
      && !regWdata[1] |=> sarConvert;
  endproperty
  property p_irq; irq |-> maskQ != 2'h0; endproperty
  property p_pins;
    pinDigitalMode == ((pcfgQ | otherModulePortConfig) & presMask) && muxToGround == pinDigitalMode;
  endproperty
  property p_scan; regRd && regAddr == `SAS_OFS_SCAN |=> regRdata == {3'h0, scanQ}; endproperty
  property p_unmap; regRd && regAddr > `SAS_OFS_IRQMSK |=> regRdata == 16'h0000; endproperty
  a_excl: assert property (p_excl) else $error("sample and convert together");
  a_after: assert property (p_after) else $error("convert without sampling");
  a_len: assert property (p_len) else $error("conversion too short");
  a_start: assert property (p_start) else $error("sampling not started");
  a_end: assert property (p_end) else $error("manual convert not started");
  a_irq: assert property (p_irq) else $error("irq while masked");
  a_pins: assert property (p_pins) else $error("digital pin not grounded");
  a_scan: assert property (p_scan) else $error("scan select readback");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_conv: cover property ($rose(sarConvert));
  c_irq: cover property ($rose(irq));
  c_pin: cover property (|pinDigitalMode);
endmodule : sas_sequencer_sva
bind sas_sequencer sas_sequencer_sva #(.PRESENT_INPUTS(PRESENT_INPUTS)) u_sva (.clk, .rst_n, .regAddr, .regWdata,
  .regWr, .regRd, .regRdata, .otherModulePortConfig, .sampleConnect, .sarConvert, .pinDigitalMode, .muxToGround, .irq);

// >>> test/sas_analog_model.sv
module sas_analog_model #(
  parameter int SLOW = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleConnect,
  input wire logic sarConvert,
  output logic     sarBitDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] divQ;
  // Bit decisions only while the capacitor holds, never while it tracks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) divQ <= '0;
    else if (!sarConvert || sampleConnect) divQ <= '0;
    else divQ <= (divQ == 4'(SLOW)) ? 4'h0 : divQ + 4'h1;
  end
  assign sarBitDone = sarConvert && !sampleConnect && divQ == 4'(SLOW);
endmodule : sas_analog_model

// >>> test/sas_sequencer_bench.sv
`include "sas_regs.svh"
module sas_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PRES = 10;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, extTrigger = 0, timerTrigger = 0;
  logic [3:0]  regAddr = '0;
  logic [15:0] regWdata = '0, regRdata;
  logic [12:0] otherCfg = '0, pinDigitalMode, muxToGround;
  logic        sarBitDone, sampleConnect, sarConvert, irq, bufferHalf, prev;
  logic [1:0]  activeChannels, chan123Neg;
  logic [4:0]  chan0Pos;
  logic [3:0]  resultSlot;
  logic        chan0Neg, chan123Pos, selNegRef;
  logic [31:0] lfsrQ = 32'hd5a80fad;
  int          fails = 0, comparisons = 0, cnt;
  always #50 clk = ~clk;
  sas_sequencer #(.PRESENT_INPUTS(PRES)) dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .extTrigger, .timerTrigger, .otherModulePortConfig(otherCfg), .sarBitDone, .sampleConnect, .sarConvert,
    .chan0PosSelect(chan0Pos), .chan0NegSelect(chan0Neg), .chan123PosSelect(chan123Pos),
    .chan123NegSelect(chan123Neg), .activeChannels, .selectNegReference(selNegRef), .pinDigitalMode, .muxToGround,
    .bufferHalf, .resultSlot, .irq);
  sas_analog_model #(.SLOW(2)) u_far (.clk, .rst_n, .sampleConnect, .sarConvert, .sarBitDone);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [15:0] exp_pins(input logic [12:0] a, input logic [12:0] b);
    return {3'h0, (a | b) & ((13'h1 << PRES) - 13'h1)};
  endfunction : exp_pins
  function automatic logic [1:0] exp_chan(input logic twelve, input logic [1:0] channel_count_select);
    return twelve ? 2'h0 : channel_count_select;
  endfunction : exp_chan
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 check(regRdata, e);
    @(posedge clk);
  endtask : rd
  // Bounded wait on irq (0) or sarConvert (1)
  task automatic waitsig(input int s, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if ((s == 0 ? irq : sarConvert) === v) break;
    end
    if (n == 3000) begin fails++; tally_and_finish(); end
  endtask : waitsig
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
    repeat (4) begin
      lfsrQ = lfsr_next(lfsrQ);
      otherCfg <= lfsrQ[28:16] ^ lfsrQ[12:0];
      wr(`SAS_OFS_SCAN, lfsrQ[15:0]);
      wr(`SAS_OFS_PORT_ANALOG_CONFIG_BITS, lfsrQ[31:16]);
      rd(`SAS_OFS_SCAN, {3'h0, lfsrQ[12:0]});
      rd(`SAS_OFS_PORT_ANALOG_CONFIG_BITS, {3'h0, lfsrQ[28:16]});
      check(16'(pinDigitalMode), exp_pins(lfsrQ[28:16], otherCfg));
      check(16'(muxToGround), exp_pins(lfsrQ[28:16], otherCfg));
    end
    for (int m = 0; m < 8; m++) begin
      wr(`SAS_OFS_CTL1, {5'h0, m[2], 10'h0});
      wr(`SAS_OFS_CTL2, {6'h0, m[1:0], 8'h0});
      check(16'(activeChannels), 16'(exp_chan(m[2], m[1:0])));
      rd(`SAS_OFS_CTL2, {6'h0, exp_chan(m[2], m[1:0]), 8'h0});
    end
    wr(`SAS_OFS_CTL1, 16'h0002);
    repeat (5) @(posedge clk);
    check(16'(sampleConnect), 16'h0001);
    wr(`SAS_OFS_CTL1, 16'h0000);
    check(16'(sarConvert), 16'h0001);
    waitsig(1, 1'b0);
    rd(`SAS_OFS_CTL1, 16'h0001);
    check(16'(irq), 16'h0000);
    wr(`SAS_OFS_IRQMSK, 16'h0002);
    check(16'(irq), 16'h0001);
    wr(`SAS_OFS_IRQST, 16'h0002);
    check(16'(irq), 16'h0000);
    for (int t = 1; t < 3; t++) begin
      wr(`SAS_OFS_CTL1, {8'h0, 3'(t), 5'h02});
      repeat (3) @(posedge clk);
      check(16'(sampleConnect), 16'h0001);
      if (t == 1) extTrigger <= 1'b1;
      else timerTrigger <= 1'b1;
      @(posedge clk);
      extTrigger <= 1'b0;
      timerTrigger <= 1'b0;
      waitsig(1, 1'b1);
      rd(`SAS_OFS_CTL1, {8'h0, 3'(t), 5'h00});
      waitsig(1, 1'b0);
    end
    lfsrQ = lfsr_next(lfsrQ);
    wr(`SAS_OFS_IRQST, 16'h0003);
    wr(`SAS_OFS_IRQMSK, 16'h0001);
    wr(`SAS_OFS_CTL3, 16'h0201);
    wr(`SAS_OFS_CTL2, {12'h0, lfsrQ[1:0], 2'b10});
    wr(`SAS_OFS_CTL1, 16'h00e4);
    cnt = 0; prev = 1'b0;
    for (int n = 0; n < 3000 && irq !== 1'b1; n++) begin
      @(posedge clk);
      if (prev && !sarConvert) cnt++;
      prev = sarConvert;
    end
    if (irq !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    check(16'(cnt), 16'(lfsrQ[1:0]) + 16'h1);
    check(16'(sampleConnect), 16'h0001);
    check(16'(bufferHalf), 16'h0001);
    rd(`SAS_OFS_CTL2, {8'h00, 1'b1, 1'b0, 2'b00, lfsrQ[1:0], 2'b10});
    wr(`SAS_OFS_CTL1, 16'h0000);
    waitsig(1, 1'b0);
    // Second reset mid-run, then mux selects, alternation, slot, 12-bit length and scan
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(16'(bufferHalf), 16'h0000);
    lfsrQ = lfsr_next(lfsrQ);
    wr(`SAS_OFS_CHS0, lfsrQ[15:0]);
    wr(`SAS_OFS_CHS123, lfsrQ[31:16]);
    wr(`SAS_OFS_CTL2, 16'h000d);
    @(posedge clk);
    check(16'(chan0Pos), 16'(lfsrQ[4:0]));
    check(16'(chan0Neg), 16'(lfsrQ[7]));
    check(16'(chan123Pos), 16'(lfsrQ[16]));
    check(16'(chan123Neg), 16'(lfsrQ[18:17]));
    check(16'(resultSlot), 16'h0000);
    wr(`SAS_OFS_CTL1, 16'h0402);
    wr(`SAS_OFS_CTL1, 16'h0400);
    cnt = 0;
    for (int n = 0; n < 100 && sarConvert === 1'b1; n++) begin
      @(posedge clk);
      cnt++;
    end
    @(posedge clk);
    check(16'(cnt), 16'(`SAS_CONV_TAD_12));
    check(16'(chan0Pos), 16'(lfsrQ[12:8]));
    check(16'(chan0Neg), 16'(lfsrQ[15]));
    check(16'(chan123Pos), 16'(lfsrQ[24]));
    check(16'(chan123Neg), 16'(lfsrQ[26:25]));
    check(16'(resultSlot), 16'h0001);
    wr(`SAS_OFS_SCAN, 16'h0c04);
    wr(`SAS_OFS_CTL2, 16'h0400);
    repeat (2) @(posedge clk);
    check(16'(chan0Pos), 16'h0002);
    check(16'(selNegRef), 16'h0000);
    wr(`SAS_OFS_CTL1, 16'h0002);
    wr(`SAS_OFS_CTL1, 16'h0000);
    waitsig(1, 1'b0);
    @(posedge clk);
    check(16'(chan0Pos), 16'h000a);
    check(16'(selNegRef), 16'h0001);
    tally_and_finish();
  end
endmodule : sas_sequencer_bench
